// ---- core/mirf_defs.vh ----
// Constants for the MAC interrupt mask and receive filter register slice
`ifndef MIRF_DEFS_VH
`define MIRF_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MIRF_OFF_STAT_RAW 8'h00
`define MIRF_OFF_STAT_MASKED 8'h04
`define MIRF_OFF_MASK_SET 8'h08
`define MIRF_OFF_MASK_CLEAR 8'h0C
`define MIRF_OFF_FILTER_EN 8'h10
`define MIRF_OFF_IRQ_STATUS 8'h14
`define MIRF_OFF_IRQ_CLEAR 8'h18
`define MIRF_OFF_IRQ_ENABLE 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MIRF_BIT_HOST 1
`define MIRF_BIT_STAT 0
`define MIRF_BIT_PASSCRC 30
`define MIRF_BIT_QOS 29
`define MIRF_BIT_NOCHAIN 28
`define MIRF_BIT_CMF 24
`define MIRF_BIT_SHORT 23
`define MIRF_BIT_ERRFRM 22
`define MIRF_BIT_ALLFRM 21
`define MIRF_BIT_BCAST_EN 13
`define MIRF_BIT_MCAST_EN 5
// Writable bits of the filter enable register
`define MIRF_FILTER_WMASK 32'h71E7_2727

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MIRF_RST_MASK 2'h0
`define MIRF_RST_FILTER 32'h0000_0000
`define MIRF_RST_IRQ 2'h0
`define MIRF_RST_WORD 32'h0000_0000
`define MIRF_RST_BIT 1'b0

`endif

// ---- core/mirf_sync2.v ----
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module mirf_sync2 (
   input wire clock,
   input wire rst_b,
   input wire d,
   output wire q
);
   reg meta_ff;
   reg sync_ff;

   // Two stages, first read only by second
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule
`default_nettype wire

// ---- core/mirf_regs.v ----
// MAC interrupt mask and receive filter register slice
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mirf_defs.vh"
module mirf_regs (
   input wire clock,
   input wire rst_b,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata,
   input wire host_error_pending,
   input wire statistics_pending,
   output reg host_error_irq,
   output reg statistics_irq,
   output reg rx_crc_passthrough,
   output reg rx_qos_enable,
   output reg rx_single_buffer_only,
   output reg rx_copy_control_frames,
   output reg [31:0] rx_filter_cfg,
   output reg irq
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   wire host_pend_s;
   wire stat_pend_s;

   mirf_sync2 u_sync_host (
      .clock(clock),
      .rst_b(rst_b),
      .d(host_error_pending),
      .q(host_pend_s)
   );

   mirf_sync2 u_sync_stat (
      .clock(clock),
      .rst_b(rst_b),
      .d(statistics_pending),
      .q(stat_pend_s)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg [1:0] mask_ff;
   reg [31:0] filter_ff;
   reg [1:0] irq_stat_ff;
   reg [1:0] irq_en_ff;
   reg [1:0] masked_prev_ff;
   reg [1:0] nxt_mask;
   reg [31:0] nxt_filter;
   reg [1:0] nxt_irq_stat;
   reg [1:0] nxt_irq_en;
   reg [31:0] nxt_rdata;

   wire [1:0] raw_pend;
   wire [1:0] masked;
   wire [1:0] masked_prev;
   wire [1:0] rise;
   wire hit_set;
   wire hit_clr;
   wire hit_flt;
   wire hit_icl;
   wire hit_ien;
   wire wr_set;
   wire wr_clr;
   wire wr_flt;
   wire wr_icl;
   wire wr_ien;
   wire irq_any;
   wire [31:0] word_raw;
   wire [31:0] word_masked;
   wire [31:0] word_mask;
   wire [31:0] word_filter;
   wire [31:0] word_stat;
   wire [31:0] word_en;

   // ----------------------------------------------------------------
   // Masked view and edge detection
   // ----------------------------------------------------------------
   // Synchronised raw sources, host error in bit 1
   assign raw_pend = {host_pend_s, stat_pend_s};
   // Masked view is raw AND mask
   assign masked = raw_pend & mask_ff;
   // A source turns visible by its own rise or by a mask set
   assign masked_prev = masked_prev_ff;
   assign rise = masked & ~masked_prev;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Exact byte-address match per writable register
   assign hit_set = (addr == `MIRF_OFF_MASK_SET);
   assign hit_clr = (addr == `MIRF_OFF_MASK_CLEAR);
   assign hit_flt = (addr == `MIRF_OFF_FILTER_EN);
   assign hit_icl = (addr == `MIRF_OFF_IRQ_CLEAR);
   assign hit_ien = (addr == `MIRF_OFF_IRQ_ENABLE);

   // Writes qualified by the strobe; reads never change state
   assign wr_set = wr_stb && hit_set;
   assign wr_clr = wr_stb && hit_clr;
   assign wr_flt = wr_stb && hit_flt;
   assign wr_icl = wr_stb && hit_icl;
   assign wr_ien = wr_stb && hit_ien;

   // ----------------------------------------------------------------
   // Mask set and clear
   // ----------------------------------------------------------------
   // Set ORs in ones, clear removes ones; zeros do nothing
   always @* begin
      nxt_mask = mask_ff;
      if (wr_set) begin
         nxt_mask = mask_ff | wdata[1:0];
      end
      if (wr_clr) begin
         nxt_mask = mask_ff & ~wdata[1:0];
      end
   end

   // Both enables start off, so no source reaches the masked view or the interrupts
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mask_ff <= `MIRF_RST_MASK;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // ----------------------------------------------------------------
   // Receive filter enable
   // ----------------------------------------------------------------
   // Reserved bits never store, so they read back as zero
   always @* begin
      nxt_filter = filter_ff;
      if (wr_flt) begin
         nxt_filter = wdata & `MIRF_FILTER_WMASK;
      end
   end

   // Whole filter word
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         filter_ff <= `MIRF_RST_FILTER;
      end else begin
         filter_ff <= nxt_filter;
      end
   end

   // ----------------------------------------------------------------
   // Event status and enable
   // ----------------------------------------------------------------
   // Masked view one cycle back, for the edge detector
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         masked_prev_ff <= `MIRF_RST_MASK;
      end else begin
         masked_prev_ff <= masked;
      end
   end

   // Sticky events; a new event wins over a clear
   always @* begin
      nxt_irq_stat = irq_stat_ff;
      if (wr_icl) begin
         nxt_irq_stat = irq_stat_ff & ~wdata[1:0];
      end
      nxt_irq_stat = nxt_irq_stat | rise;
   end

   // Sticky event register
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_ff <= `MIRF_RST_IRQ;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // Event enable, whole field replaced on write
   always @* begin
      nxt_irq_en = irq_en_ff;
      if (wr_ien) begin
         nxt_irq_en = wdata[1:0];
      end
   end

   // Event enable register
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_en_ff <= `MIRF_RST_IRQ;
      end else begin
         irq_en_ff <= nxt_irq_en;
      end
   end

   // Any enabled event held
   assign irq_any = |(irq_stat_ff & irq_en_ff);

   // ----------------------------------------------------------------
   // Register words
   // ----------------------------------------------------------------
   // Each register as software sees it; reserved bits read zero
   assign word_raw = {30'h0, raw_pend};
   assign word_masked = {30'h0, masked};
   assign word_mask = {30'h0, mask_ff};
   assign word_filter = filter_ff;
   assign word_stat = {30'h0, irq_stat_ff};
   assign word_en = {30'h0, irq_en_ff};

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Read data for the addressed register, zero when unmapped
   always @* begin
      nxt_rdata = 32'h0000_0000;
      case (addr)
         `MIRF_OFF_STAT_RAW: nxt_rdata = word_raw;
         `MIRF_OFF_STAT_MASKED: nxt_rdata = word_masked;
         `MIRF_OFF_MASK_SET: nxt_rdata = word_mask;
         `MIRF_OFF_MASK_CLEAR: nxt_rdata = word_mask;
         `MIRF_OFF_FILTER_EN: nxt_rdata = word_filter;
         `MIRF_OFF_IRQ_STATUS: nxt_rdata = word_stat;
         `MIRF_OFF_IRQ_ENABLE: nxt_rdata = word_en;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Read data stands one cycle after the strobe, zero otherwise
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `MIRF_RST_WORD;
      end else begin
         rdata <= rd_stb ? nxt_rdata : 32'h0000_0000;
      end
   end

   // Masked host error level
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         host_error_irq <= `MIRF_RST_BIT;
      end else begin
         host_error_irq <= masked[`MIRF_BIT_HOST];
      end
   end

   // Masked statistics level
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         statistics_irq <= `MIRF_RST_BIT;
      end else begin
         statistics_irq <= masked[`MIRF_BIT_STAT];
      end
   end

   // CRC kept when 1, dropped when 0
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_crc_passthrough <= `MIRF_RST_BIT;
      end else begin
         rx_crc_passthrough <= filter_ff[`MIRF_BIT_PASSCRC];
      end
   end

   // Quality of service handling on the receive path
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_qos_enable <= `MIRF_RST_BIT;
      end else begin
         rx_qos_enable <= filter_ff[`MIRF_BIT_QOS];
      end
   end

   // Single-buffer mode to receive DMA
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_single_buffer_only <= `MIRF_RST_BIT;
      end else begin
         rx_single_buffer_only <= filter_ff[`MIRF_BIT_NOCHAIN];
      end
   end

   // Control frames stored when set
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_copy_control_frames <= `MIRF_RST_BIT;
      end else begin
         rx_copy_control_frames <= filter_ff[`MIRF_BIT_CMF];
      end
   end

   // Whole filter word for the address match logic
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_filter_cfg <= `MIRF_RST_WORD;
      end else begin
         rx_filter_cfg <= filter_ff;
      end
   end

   // Level interrupt, high while an enabled event is held
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq <= `MIRF_RST_BIT;
      end else begin
         irq <= irq_any;
      end
   end
endmodule
`default_nettype wire

// ---- sim/mirf_regs_monitor.sv ----
// Port checker for the MAC irq mask and receive filter slice
`timescale 1ns/1ps
`default_nettype none
module mirf_regs_monitor (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   input wire logic host_error_pending,
   input wire logic statistics_pending,
   input wire logic host_error_irq,
   input wire logic statistics_irq,
   input wire logic rx_crc_passthrough,
   input wire logic rx_qos_enable,
   input wire logic rx_single_buffer_only,
   input wire logic rx_copy_control_frames,
   input wire logic [31:0] rx_filter_cfg,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ---------------------------------------------
   // Mask, status and filter checks
   // ---------------------------------------------
   stat_zero_a: assert property (rd_stb && addr == 8'h04
      |=> rdata[31:2] == 30'h0) else $error("status high bits set");
   host_set_a: assert property (
      wr_stb && addr == 8'h08 && wdata[1]
      ##1 !(wr_stb && addr == 8'h0C && wdata[1])
      |=> host_error_irq == $past(host_error_pending, 3))
      else $error("host enable failed");
   stat_set_a: assert property (
      wr_stb && addr == 8'h08 && wdata[0]
      ##1 !(wr_stb && addr == 8'h0C && wdata[0])
      |=> statistics_irq == $past(statistics_pending, 3))
      else $error("stat enable failed");
   host_clr_a: assert property (wr_stb && addr == 8'h0C && wdata[1]
      |=> ##1 !host_error_irq) else $error("host disable failed");
   stat_clr_a: assert property (wr_stb && addr == 8'h0C && wdata[0]
      |=> ##1 !statistics_irq) else $error("stat disable failed");
   filt_wr_a: assert property (wr_stb && addr == 8'h10
      |=> ##1 rx_filter_cfg == ($past(wdata, 2) & 32'h71E7_2727))
      else $error("filter write wrong");
   field_out_a: assert property (wr_stb && addr == 8'h10 |=> ##1
      {rx_crc_passthrough, rx_qos_enable, rx_single_buffer_only,
      rx_copy_control_frames} ==
      {$past(wdata[30:28], 2), $past(wdata[24], 2)})
      else $error("filter fields wrong");
   rst_clear_a: assert property ($rose(rst_b)
      |-> rx_filter_cfg == 32'h0000_0000 && !irq) else $error("reset state");
   // Main scenarios
   cover property (rd_stb && addr == 8'h04 ##1 rdata[1:0] == 2'h3);
   cover property (irq);
   cover property (wr_stb && addr == 8'h0C && wdata[1:0] == 2'h3);
endmodule
bind mirf_regs mirf_regs_monitor u_mon (.clock, .rst_b, .addr, .wdata,
   .wr_stb, .rd_stb, .rdata, .host_error_pending, .statistics_pending,
   .host_error_irq, .statistics_irq, .rx_crc_passthrough, .rx_qos_enable,
   .rx_single_buffer_only, .rx_copy_control_frames, .rx_filter_cfg, .irq);
`default_nettype wire

// ---- sim/mirf_regs_bench.sv ----
// Random register and interrupt test of the mask and filter slice
`timescale 1ns/1ps
`default_nettype none
module mirf_regs_bench;
   logic clock = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, hp = 0, sp = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, cfg;
   logic hi, si, crc, qos, one, cmf, irq;
   int err_total = 0, n_compared = 0, seed = 32'hd640;
   int mask, filt, stk, en, pm, k, a, d;
   always #2.5 clock = ~clock;
   mirf_regs u_mirf_regs (.clock, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
      .rdata, .host_error_pending(hp), .statistics_pending(sp),
      .host_error_irq(hi), .statistics_irq(si), .rx_crc_passthrough(crc),
      .rx_qos_enable(qos), .rx_single_buffer_only(one),
      .rx_copy_control_frames(cmf), .rx_filter_cfg(cfg), .irq);
   task cmp(input logic [31:0] got, input int exp);
      n_compared++;
      if (got !== exp[31:0]) begin
         err_total++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp[31:0]);
      end
   endtask
   task wr(input int ad, input int dt);
      @(posedge clock);
      addr <= ad[7:0];
      wdata <= dt;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask
   task rd(input int ad, input int exp);
      @(posedge clock);
      addr <= ad[7:0];
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 cmp(rdata, exp);
   endtask
   // Let pipelines land, then track sticky events in the model
   task settle;
      repeat (6) @(posedge clock);
      k = {hp, sp} & mask;
      stk |= k & ~pm;
      pm = k;
   endtask
   task check_all;
      rd(8'h04, k);
      rd(8'h08, mask);
      rd(8'h0C, mask);
      rd(8'h10, filt);
      // Read data falls back to zero after its one cycle
      @(posedge clock);
      #1 cmp(rdata, 0);
      rd(8'h14, stk);
      rd(8'h1C, en);
      rd(8'h00, {hp, sp});
      rd(8'h18, 0);
      rd(8'h24, 0);
      cmp({hi, si, irq}, {k[1:0], |(stk & en)});
      cmp({crc, qos, one, cmf}, {filt[30:28], filt[24]});
      cmp(cfg, filt);
   endtask
   task restart;
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      {mask, filt, stk, en, pm} = 0;
      settle;
      check_all;
   endtask
   task close_out;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence: reset, random traffic, reset again
   initial begin
      restart;
      $display("test reset done");
      for (int i = 0; i < 300; i++) begin
         a = $random(seed);
         d = $random(seed);
         case (a & 7)
            0: begin
               @(posedge clock);
               hp <= d[0];
               sp <= d[1];
            end
            1: wr(8'h08, d);
            2: wr(8'h0C, d);
            3: wr(8'h10, d);
            4: wr(8'h18, d);
            5: wr(8'h1C, d);
            6: wr(a[8] ? 8'h04 : 8'h14, d);
            default: wr({1'b1, a[14:8]}, d);
         endcase
         case (a & 7)
            1: mask |= d & 3;
            2: mask &= ~d;
            3: filt = d & 32'h71E7_2727;
            4: stk &= ~d;
            5: en = d & 3;
            default: ;
         endcase
         settle;
         check_all;
      end
      $display("test random done");
      restart;
      $display("test second reset done");
      close_out;
   end
   // Watchdog
   initial begin
      #100000;
      err_total++;
      close_out;
   end
endmodule
`default_nettype wire
